// ==== protector_pkg.sv ====
package protector_pkg;
    // register indices and byte addresses (index times four)
    localparam logic [7:0] idx_uv_config_one = 8'h04;
    localparam logic [7:0] idx_uv_config_two = 8'h05;
    localparam logic [7:0] idx_discharge_overcurrent_delay = 8'h06;
    localparam logic [7:0] addr_uv_config_one = {idx_uv_config_one[5:0], 2'b00};
    localparam logic [7:0] addr_uv_config_two = {idx_uv_config_two[5:0], 2'b00};
    localparam logic [7:0] addr_discharge_overcurrent_delay = {idx_discharge_overcurrent_delay[5:0], 2'b00};
    localparam logic [7:0] addr_pack_config = 8'h20;
    localparam logic [7:0] addr_event_status = 8'h24;
    localparam logic [7:0] addr_event_clear = 8'h28;
    localparam logic [7:0] addr_event_enable = 8'h2c;
    localparam logic [7:0] addr_live_state = 8'h30;

    typedef struct packed {
        logic hysteresis_inhibit;
        logic [2:0] unused;
        logic [3:0] trip_select;
    } uv_config_one_type;

    typedef struct packed {
        logic recovery_load_gate;
        logic shutdown_on_persist;
        logic [1:0] hysteresis_select;
        logic unused;
        logic [2:0] delay_select;
    } uv_config_two_type;

    typedef struct packed {
        logic shutdown;
        logic ocd_fault;
        logic uv_recovered;
        logic uv_fault;
    } event_type;

    localparam logic [7:0] uv_config_one_reset = 8'h00;
    localparam logic [7:0] uv_config_two_reset = 8'h00;
    localparam logic [7:0] discharge_overcurrent_delay_reset = 8'h00;
    localparam logic [2:0] pack_config_reset = 3'h2;

    // voltages in units of 0.1 V
    localparam logic [5:0] trip_base_dv = 6'h0e;
    localparam logic [5:0] hyst_step_dv = 6'h04;
    localparam logic [5:0] recovery_clamp_dv = 6'h23;

    // cell count select: 2 gives 8 cells down to 6 giving 4
    localparam int unsigned max_cells = 8;
    localparam logic [2:0] pack_code_first = 3'h2;
    localparam logic [2:0] pack_code_last = 3'h6;
    localparam logic [3:0] pack_count_base = 4'ha;

    // timebase and delays
    localparam int unsigned clk_mhz = 100;
    localparam int unsigned tick_period_us = 10000;
    localparam int unsigned tick_ms = tick_period_us / 1000;
    localparam int unsigned timer_width = 12;
    localparam logic [2:0] uv_delay_off = 3'h7;
    localparam int unsigned uv_delay_base_ms = 500;
    localparam int unsigned uv_delay_base_ticks = uv_delay_base_ms / tick_ms;
    localparam int unsigned persist_ms = 8000;
    localparam int unsigned persist_ticks = persist_ms / tick_ms + 1;
    localparam logic [4:0] ocd_fine_last = 5'h0e;
    localparam logic [4:0] ocd_knee_code = 5'h0f;
    localparam logic [4:0] ocd_coarse_first = 5'h10;
    localparam int unsigned ocd_fine_step_ms = 20;
    localparam int unsigned ocd_knee_ms = 400;
    localparam int unsigned ocd_coarse_base_ms = 500;
    localparam int unsigned ocd_coarse_step_ms = 100;
    localparam int unsigned ocd_fine_ticks = ocd_fine_step_ms / tick_ms;
    localparam int unsigned ocd_knee_ticks = ocd_knee_ms / tick_ms;
    localparam int unsigned ocd_coarse_base_ticks = ocd_coarse_base_ms / tick_ms;
    localparam int unsigned ocd_coarse_ticks = ocd_coarse_step_ms / tick_ms;
endpackage

// ==== delay_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module delay_timer
    import protector_pkg::*;
#(
    parameter int unsigned width = timer_width
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // timing
    input wire logic tick,
    input wire logic active,
    input wire logic [width-1:0] limit,
    // result
    output logic expired
);
    logic [width-1:0] count;
    wire logic [width-1:0] next_count;
    wire logic reach;

    if (width < 2) begin : g_bad_width
        $error("delay_timer width too small");
    end

    assign next_count = width'(count + 1'b1);
    assign reach = next_count >= limit;

    // a dropped condition restarts the count so glitches never accumulate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            expired <= 1'b0;
        end else if (!active) begin
            count <= '0;
            expired <= 1'b0;
        end else if (tick && !expired) begin
            count <= next_count;
            expired <= reach;
        end
    end

    chk_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
        !active |=> (count == '0) && !expired)
        else $error("timer did not restart when condition dropped");
    chk_timer_expiry: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(expired) |-> count == limit)
        else $error("timer expired at wrong count");
endmodule
`default_nettype wire

// ==== uv_protector.sv ====
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module uv_protector
    import protector_pkg::*;
#(
    parameter int unsigned tick_cycles = tick_period_us * clk_mhz
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // comparator results, one bit per cell, then charger, load and overcurrent inputs
    input wire logic [max_cells-1:0] cell_below_trip,
    input wire logic [max_cells-1:0] cell_below_recovery,
    input wire logic charger_present,
    input wire logic load_removed,
    input wire logic discharge_overcurrent,
    // comparator thresholds in 0.1 V units
    output logic [5:0] uv_trip_level,
    output logic [5:0] uv_recovery_level,
    // protection outputs
    output logic uv_fault,
    output logic ocd_fault,
    output logic charge_switch_drive,
    output logic shutdown_request,
    output logic irq
);
    typedef enum logic [2:0] {
        st_normal = 3'b001,
        st_uv_fault = 3'b010,
        st_shutdown = 3'b100
    } state_type;

    if (tick_cycles < 2) begin : g_bad_tick
        $error("tick_cycles must be at least 2");
    end

    state_type state, next_state;
    uv_config_one_type uv_config_one;
    uv_config_two_type uv_config_two;
    logic [4:0] discharge_overcurrent_delay;
    logic [2:0] pack_cell_count_select;
    event_type event_status, event_enable;
    logic [31:0] tick_count;
    logic tick;

    // apb decode
    wire logic access = psel && penable;
    wire logic wr_fire = access && pready && pwrite;
    wire logic hit_one = paddr == addr_uv_config_one;
    wire logic hit_two = paddr == addr_uv_config_two;
    wire logic hit_ocd = paddr == addr_discharge_overcurrent_delay;
    wire logic hit_pack = paddr == addr_pack_config;
    wire logic hit_status = paddr == addr_event_status;
    wire logic hit_clear = paddr == addr_event_clear;
    wire logic hit_enable = paddr == addr_event_enable;
    wire logic hit_live = paddr == addr_live_state;
    wire logic mapped = hit_one || hit_two || hit_ocd || hit_pack || hit_status
        || hit_clear || hit_enable || hit_live;
    wire logic [31:0] live_word = {28'h0, shutdown_request, charge_switch_drive,
        ocd_fault, uv_fault};
    wire logic [31:0] read_word =
        hit_one ? {24'h0, uv_config_one} :
        hit_two ? {24'h0, uv_config_two} :
        hit_ocd ? {27'h0, discharge_overcurrent_delay} :
        hit_pack ? {29'h0, pack_cell_count_select} :
        hit_status ? {28'h0, event_status} :
        hit_enable ? {28'h0, event_enable} :
        hit_live ? live_word : 32'h0;

    // one wait state so read data and error come straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= access && !pready;
            prdata <= (access && !pready && !pwrite) ? read_word : 32'h0;
            pslverr <= access && !pready && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_config_one <= uv_config_one_reset;
            uv_config_two <= uv_config_two_reset;
            discharge_overcurrent_delay <= discharge_overcurrent_delay_reset[4:0];
            pack_cell_count_select <= pack_config_reset;
            event_enable <= '0;
        end else if (wr_fire) begin
            if (hit_one)
                uv_config_one <= pwdata[7:0];
            if (hit_two)
                uv_config_two <= pwdata[7:0];
            if (hit_ocd)
                discharge_overcurrent_delay <= pwdata[4:0];
            if (hit_pack)
                pack_cell_count_select <= pwdata[2:0];
            if (hit_enable)
                event_enable <= pwdata[3:0];
        end
    end

    // protection timebase
    wire logic tick_wrap = tick_count == 32'(tick_cycles - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick_count <= tick_wrap ? 32'h0 : 32'(tick_count + 1'b1);
            tick <= tick_wrap;
        end
    end

    // enabled cells; unusable count codes fall back to all cells
    wire logic pack_valid = pack_cell_count_select >= pack_code_first
        && pack_cell_count_select <= pack_code_last;
    wire logic [3:0] cell_count = pack_valid
        ? 4'(pack_count_base - {1'b0, pack_cell_count_select}) : 4'(max_cells);
    wire logic [max_cells-1:0] cell_mask = max_cells'((16'h1 << cell_count) - 16'h1);
    wire logic any_below_trip = |(cell_below_trip & cell_mask);
    wire logic any_below_recovery = |(cell_below_recovery & cell_mask);

    // thresholds; unused fields are read back over APB only
    wire logic [5:0] trip_dv = 6'(trip_base_dv + {2'b00, uv_config_one.trip_select});
    wire logic [5:0] hyst_dv = 6'(hyst_step_dv * ({4'h0, uv_config_two.hysteresis_select} + 6'h1));
    wire logic [6:0] sum_dv = 7'(trip_dv + hyst_dv);
    wire logic [5:0] clamped_dv = (sum_dv > {1'b0, recovery_clamp_dv})
        ? recovery_clamp_dv : sum_dv[5:0];
    wire logic [5:0] recovery_dv = uv_config_one.hysteresis_inhibit ? trip_dv : clamped_dv;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_trip_level <= trip_base_dv;
            uv_recovery_level <= trip_base_dv;
        end else begin
            uv_trip_level <= trip_dv;
            uv_recovery_level <= recovery_dv;
        end
    end

    // delay limits in timebase ticks
    wire logic [2:0] uv_code = uv_config_two.delay_select;
    wire logic [4:0] ocd_code = discharge_overcurrent_delay;
    wire logic [timer_width-1:0] uv_limit = timer_width'(uv_delay_base_ticks << uv_code);
    wire logic [timer_width-1:0] ocd_limit =
        (ocd_code <= ocd_fine_last) ? timer_width'((ocd_code + 1) * ocd_fine_ticks) :
        (ocd_code == ocd_knee_code) ? timer_width'(ocd_knee_ticks) :
        timer_width'(ocd_coarse_base_ticks
            + (ocd_code - ocd_coarse_first) * ocd_coarse_ticks);
    wire logic [timer_width-1:0] persist_limit = timer_width'(persist_ticks);

    wire logic uv_active = state == st_normal && any_below_trip && uv_code != uv_delay_off;
    wire logic persist_active = state == st_uv_fault && uv_config_two.shutdown_on_persist
        && any_below_recovery;
    wire logic uv_expired, persist_expired, ocd_expired;

    delay_timer #(.width(timer_width)) uv_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .active(uv_active),
        .limit(uv_limit),
        .expired(uv_expired)
    );

    delay_timer #(.width(timer_width)) persist_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .active(persist_active),
        .limit(persist_limit),
        .expired(persist_expired)
    );

    delay_timer #(.width(timer_width)) ocd_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .active(discharge_overcurrent),
        .limit(ocd_limit),
        .expired(ocd_expired)
    );

    // recovery condition; load gate adds the load-removed term
    wire logic all_recovered = !any_below_recovery;
    wire logic recover_ok = all_recovered
        && (!uv_config_two.recovery_load_gate || load_removed);

    // shutdown is left only by reset; persist has priority over recovery
    always_comb begin
        next_state = state;
        case (state)
            st_normal: begin
                if (uv_expired && uv_code != uv_delay_off)
                    next_state = st_uv_fault;
            end
            st_uv_fault: begin
                // a stale expiry must not shut down once the persist bit is cleared
                if (persist_expired && uv_config_two.shutdown_on_persist)
                    next_state = st_shutdown;
                else if (recover_ok)
                    next_state = st_normal;
            end
            st_shutdown: begin
                next_state = st_shutdown;
            end
            default: begin
                next_state = st_normal;
            end
        endcase
    end

    // charging is allowed in the fault when a charger is present and no load gate holds it off
    wire logic next_charge = next_state == st_normal || (next_state == st_uv_fault
        && !uv_config_two.recovery_load_gate && charger_present);

    event_type new_events;
    assign new_events.uv_fault = state == st_normal && next_state == st_uv_fault;
    assign new_events.uv_recovered = state == st_uv_fault && next_state == st_normal;
    assign new_events.ocd_fault = ocd_expired && !ocd_fault;
    assign new_events.shutdown = state == st_uv_fault && next_state == st_shutdown;
    wire event_type clear_mask = (wr_fire && hit_clear) ? event_type'(pwdata[3:0]) : '0;
    // a new event wins over a clear written in the same cycle
    wire event_type next_status = (event_status & ~clear_mask) | new_events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_normal;
            uv_fault <= 1'b0;
            ocd_fault <= 1'b0;
            charge_switch_drive <= 1'b1;
            shutdown_request <= 1'b0;
            event_status <= '0;
            irq <= 1'b0;
        end else begin
            state <= next_state;
            uv_fault <= next_state != st_normal;
            ocd_fault <= ocd_expired;
            charge_switch_drive <= next_charge;
            shutdown_request <= next_state == st_shutdown;
            event_status <= next_status;
            irq <= |(next_status & event_enable);
        end
    end

    chk_hyst_inhibit_level: assert property (@(posedge pclk) disable iff (!presetn)
        uv_config_one.hysteresis_inhibit && $stable(uv_config_one) |=>
            uv_recovery_level == uv_trip_level)
        else $error("inhibited hysteresis still applied");
    chk_trip_level_map: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> uv_trip_level == 6'(trip_base_dv + $past(uv_config_one.trip_select)))
        else $error("trip level does not follow select");
    chk_recover_no_gate: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_uv_fault && !uv_config_two.recovery_load_gate && all_recovered
            && !persist_expired |=> !uv_fault && charge_switch_drive)
        else $error("fault did not clear on recovery");
    chk_recover_load_gate: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_uv_fault && uv_config_two.recovery_load_gate && !load_removed
            |=> uv_fault && !charge_switch_drive)
        else $error("fault cleared with load present");
    chk_no_persist_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_uv_fault && !uv_config_two.shutdown_on_persist |=> !shutdown_request)
        else $error("shutdown entered with persist bit clear");
    chk_persist_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_uv_fault && persist_expired && uv_config_two.shutdown_on_persist
            |=> shutdown_request ##1 shutdown_request)
        else $error("persisting undervoltage did not shut down");
    chk_recovery_sum: assert property (@(posedge pclk) disable iff (!presetn)
        !uv_config_one.hysteresis_inhibit && sum_dv <= 7'(recovery_clamp_dv)
            |-> recovery_dv == 6'(trip_dv + hyst_step_dv
                * ({4'h0, uv_config_two.hysteresis_select} + 6'h1)))
        else $error("recovery level not trip plus hysteresis");
    chk_recovery_clamp: assert property (@(posedge pclk) disable iff (!presetn)
        uv_recovery_level <= recovery_clamp_dv)
        else $error("recovery level above clamp");
    chk_uv_delay_off: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_normal && uv_code == uv_delay_off |=> state == st_normal)
        else $error("undervoltage tripped with detection off");
    chk_ocd_knee: assert property (@(posedge pclk) disable iff (!presetn)
        ocd_code == ocd_knee_code |-> ocd_limit == timer_width'(ocd_knee_ticks))
        else $error("overcurrent knee delay wrong");
    chk_ocd_coarse: assert property (@(posedge pclk) disable iff (!presetn)
        ocd_code == ocd_coarse_first |-> ocd_limit == timer_width'(ocd_coarse_base_ticks))
        else $error("overcurrent coarse delay wrong");
    chk_masked_cells: assert property (@(posedge pclk) disable iff (!presetn)
        (cell_below_trip & cell_mask) == '0 |-> !uv_active)
        else $error("disabled cell started undervoltage timer");
    chk_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick)
        else $error("timebase tick longer than one cycle");
    chk_tick_phase: assert property (@(posedge pclk) disable iff (!presetn)
        tick |-> tick_count == 32'h0)
        else $error("timebase tick out of phase with its divider");
    chk_trip_range: assert property (@(posedge pclk) disable iff (!presetn)
        uv_trip_level >= trip_base_dv && uv_trip_level <= 6'(trip_base_dv + 6'h0f))
        else $error("trip level outside its sixteen steps");
    chk_rec_over_trip: assert property (@(posedge pclk) disable iff (!presetn)
        uv_recovery_level >= uv_trip_level)
        else $error("recovery level below trip level");
    chk_uv_delay_base: assert property (@(posedge pclk) disable iff (!presetn)
        uv_code == 3'h0 |-> uv_limit == timer_width'(uv_delay_base_ticks))
        else $error("undervoltage base delay wrong");
    chk_ocd_fine_base: assert property (@(posedge pclk) disable iff (!presetn)
        ocd_code == 5'h00 |-> ocd_limit == timer_width'(ocd_fine_ticks))
        else $error("overcurrent first delay wrong");
    chk_charger_at_once: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_uv_fault && !uv_config_two.recovery_load_gate && charger_present
            && !persist_expired |=> charge_switch_drive)
        else $error("charger did not enable charge switch");
    chk_uv_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_uv_fault && any_below_recovery |=> uv_fault)
        else $error("fault cleared with a cell below recovery");
    chk_shutdown_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        shutdown_request |=> shutdown_request)
        else $error("shutdown request dropped without reset");
    chk_shutdown_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !shutdown_request && !uv_config_two.shutdown_on_persist |=> !shutdown_request)
        else $error("shutdown entered with persist bit clear");
    chk_ocd_release: assert property (@(posedge pclk) disable iff (!presetn)
        !discharge_overcurrent |-> ##2 !ocd_fault)
        else $error("overcurrent flag outlived its condition");

    cov_uv_trip: cover property (@(posedge pclk) disable iff (!presetn)
        new_events.uv_fault);
    cov_uv_recover: cover property (@(posedge pclk) disable iff (!presetn)
        new_events.uv_recovered);
    cov_shutdown: cover property (@(posedge pclk) disable iff (!presetn)
        new_events.shutdown);
    cov_ocd: cover property (@(posedge pclk) disable iff (!presetn)
        new_events.ocd_fault ##1 irq);
    cov_load_gate: cover property (@(posedge pclk) disable iff (!presetn)
        new_events.uv_recovered && uv_config_two.recovery_load_gate);
endmodule
`default_nettype wire

// ==== cell_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cell_model
    import protector_pkg::*;
(
    // thresholds from the protector
    input wire logic [5:0] trip,
    input wire logic [5:0] recovery,
    // cell voltages, 0.1 V units, cell n in bits 6n+5:6n
    input wire logic [47:0] volts,
    // comparator results
    output logic [max_cells-1:0] below_trip,
    output logic [max_cells-1:0] below_rec
);
    // ideal comparators: no offset, so edge cases land exactly on the level
    always_comb begin
        for (int i = 0; i < max_cells; i++) begin
            below_trip[i] = volts[i*6 +: 6] < trip;
            below_rec[i] = volts[i*6 +: 6] < recovery;
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import protector_pkg::*;
    localparam int tc = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, chg = 0, lrem = 0, ocd_in = 0, uvf, ocdf, csd, sdr, irq;
    logic [47:0] volts = {8{6'h28}};
    logic [7:0] bt, br;
    logic [5:0] trip, rec;
    logic [32:0] expq[$];
    int errors = 0, samples_checked = 0, n;
    cell_model i_cell_model(.trip(trip), .recovery(rec), .volts(volts), .below_trip(bt),
        .below_rec(br));
    uv_protector #(.tick_cycles(tc)) i_uv_protector(.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_below_trip(bt),
        .cell_below_recovery(br), .charger_present(chg), .load_removed(lrem),
        .discharge_overcurrent(ocd_in), .uv_trip_level(trip), .uv_recovery_level(rec),
        .uv_fault(uvf), .ocd_fault(ocdf), .charge_switch_drive(csd),
        .shutdown_request(sdr), .irq(irq));
    always #5 pclk = ~pclk;
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(0, a, $urandom);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
            chk("prdata", expq.pop_front(), {pslverr, prdata});
        end
    end
    function automatic logic flag(input int s);
        case (s)
            0: return ocdf;
            1: return uvf;
            default: return sdr;
        endcase
    endfunction
    task automatic wt(input int s, input int lim);
        n = 0;
        while (flag(s) !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic pause(input int k);
        repeat (k) @(posedge pclk);
    endtask
    initial begin
        repeat (95000) @(posedge pclk);
        errors++;
        results();
    end
    initial begin
        logic [7:0] c1, c2;
        logic [5:0] t, r;
        void'($urandom(57442));
        pause(20);
        presetn <= 1;
        pause(2);
        chk("rec", 18, rec);
        rd(addr_uv_config_two, 0);
        rd(addr_pack_config, 2);
        rd(8'h40, 33'h100000000);
        for (int i = 0; i < 16; i++) begin
            c1 = $urandom;
            c2 = {2'b00, 6'($urandom)};
            c1[3:0] = i;
            apb(1, addr_uv_config_one, c1);
            apb(1, addr_uv_config_two, c2);
            t = 14 + i;
            r = (t + 4 * (c2[5:4] + 1) > 35) ? 35 : t + 4 * (c2[5:4] + 1);
            pause(2);
            chk("trip", t, trip);
            chk("rec", c1[7] ? t : r, rec);
        end
        apb(1, addr_event_enable, 4);
        for (int c = 0; c < 32; c++) begin
            int lim;
            lim = c < 15 ? (c + 1) * 2 : (c == 15 ? 40 : 50 + (c - 16) * 10);
            apb(1, addr_discharge_overcurrent_delay, {27'($urandom), c[4:0]});
            rd(addr_discharge_overcurrent_delay, c);
            ocd_in <= 1;
            pause((lim - 1) * tc / 2);
            ocd_in <= 0;
            pause(1);
            ocd_in <= 1;
            wt(0, lim * tc + 20);
            chk("ocd_time", 1, n >= (lim - 1) * tc && n <= lim * tc + 6);
            ocd_in <= 0;
            pause(3);
            chk("ocd_drop", 0, ocdf);
            chk("irq_set", 1, irq);
            apb(1, addr_event_clear, 4);
            pause(2);
            chk("irq_clr", 0, irq);
        end
        apb(1, addr_uv_config_one, 0);
        for (int c = 0; c < 8; c++) begin
            apb(1, addr_uv_config_two, c);
            volts[c*6 +: 6] <= 6'h0a;
            wt(1, c == 7 ? 400 : (50 << c) * tc + 20);
            chk("uv_time", 1, c == 7 ? uvf === 1'b0 :
                n >= ((50 << c) - 1) * tc && n <= (50 << c) * tc + 6);
            chg <= 1;
            pause(2);
            chk("chg_on", 1, csd);
            chg <= 0;
            volts[c*6 +: 6] <= 6'h28;
            pause(3);
            chk("uv_clear", 0, uvf);
        end
        chk("irq_mask", 0, irq);
        rd(addr_event_status, 3);
        apb(1, addr_uv_config_two, 8'h80);
        volts[5:0] <= 6'h0a;
        wt(1, 220);
        chk("chg_gate", 0, csd);
        volts[5:0] <= 6'h28;
        pause(20);
        chk("uv_hold", 1, uvf);
        lrem <= 1;
        pause(3);
        chk("uv_load", 0, uvf);
        lrem <= 0;
        apb(1, addr_pack_config, 6);
        volts[47:42] <= 6'h0a;
        pause(260);
        chk("pack4", 0, uvf);
        volts[47:42] <= 6'h28;
        apb(1, addr_uv_config_two, 0);
        volts[5:0] <= 6'h0a;
        wt(1, 220);
        volts[5:0] <= 6'h10;
        pause(900 * tc);
        chk("no_sd", 0, sdr);
        apb(1, addr_uv_config_two, 8'h40);
        wt(2, 801 * tc + 20);
        chk("sd_time", 1, n >= 799 * tc && n <= 801 * tc + 6);
        volts[5:0] <= 6'h28;
        pause(10);
        chk("sd_stay", 1, sdr && uvf);
        rd(addr_live_state, 9);
        presetn <= 0;
        pause(2);
        presetn <= 1;
        pause(2);
        chk("sd_reset", 0, sdr);
        rd(addr_live_state, 4);
        pause(2);
        results();
    end
endmodule
`default_nettype wire
